// *** design/rta_alarm_gate.sv ***
// Purpose: alarm-zero compare, interrupt output and serial bus gating in backup
// Assumes: time advances by a one-cycle tick after counters update; supply flags are synchronous
// Notes:   registers written by reg_wr_en/reg_idx/reg_wdata from the bus engine
//
// Behaviour
// - Each compare register holds a BCD value in bits 6:0 and its match enable in bit 7.
// - A compare register written all zeros has its enable clear and that field is ignored.
// - Alarm zero only fires while the alarm enable bit 5 of interrupt control is one.
// - With mode select bit 7 zero a match gives one held alarm event, not a pulse train.
// - With mode select bit 7 one every match pulses the interrupt output low.
// - The compare is evaluated on each clock advance, so a minute match lands at seconds 59 to 00.
// - A match sets the alarm zero status flag and drives the active-low interrupt output low.
// - In pulsed mode the flag sets on every trigger and pulses continue without clearing it.
// - The bus is dead whenever the main supply is below the reset threshold in any mode.
// - In modes A and C the bus serves down to the reset threshold and never on battery.
// - In mode B the bus works on battery only while battery and main supply exceed the threshold.
// - In mode D the bus works only while the main supply exceeds both threshold and battery.
// - The interrupt output stays driven on battery in every backup mode.
// - In standard switchover on battery only timekeeping runs; alarms and bus are held off.
`timescale 1ns/10ps
module rta_alarm_gate
  import rta_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        sec_tick,
  input  wire rta_time_s   cur_time,
  input  wire rta_supply_s supply,
  input  wire logic        backup_switch_select,
  input  wire logic        bus_in_backup_select,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [2:0]  reg_idx,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             bus_enable,
  output logic             alarm_interrupt_output_n,
  output logic             alarm_interrupt_output_oe,
  output logic             low_voltage_reset_state
);

  logic [7:0] alarm_ff [6];
  logic [7:0] nxt_alarm [6];
  logic [7:0] intc_ff;
  logic [7:0] nxt_intc;
  logic       flag_ff;
  logic       nxt_flag;
  rta_irq_e   irq_ff;
  rta_irq_e   nxt_irq;
  logic [7:0] pcnt_ff;
  logic [7:0] nxt_pcnt;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       bus_ff;
  logic       nxt_bus;
  logic       lvr_ff;
  logic       irq_n_ff;
  logic       nxt_irq_n;
  logic       oe_ff;

  rta_mode_e  mode;
  logic       match;
  logic       bus_ok;
  logic       standard_batt;
  logic       wr_ok;

  // Field enabled and differs: mismatch
  function automatic logic field_miss(input logic [7:0] cmp, input logic [7:0] now);
    field_miss = cmp[MATCH_EN_BIT] && ((cmp[6:0] & BCD_MASK) != (now[6:0] & BCD_MASK));
  endfunction

  always_comb begin
    mode = rta_mode_e'({bus_in_backup_select, backup_switch_select});
    // Standard switchover modes drop everything but timekeeping on battery
    standard_batt = supply.on_battery && !backup_switch_select;
    unique case (mode)
      RTA_MODE_A, RTA_MODE_C: bus_ok = supply.vdd_above_reset && !supply.on_battery;
      RTA_MODE_B:             bus_ok = supply.vdd_above_reset &&
                                       (!supply.on_battery || supply.vbat_above_reset);
      RTA_MODE_D:             bus_ok = supply.vdd_above_reset && supply.vdd_above_vbat;
      default:                bus_ok = 1'b0;
    endcase
    if (!supply.vdd_above_reset) begin
      bus_ok = 1'b0;
    end
    wr_ok = reg_wr_en && bus_ff;
    match = sec_tick && intc_ff[ALARM_EN_BIT] && !standard_batt
            && !field_miss(alarm_ff[0], cur_time.sec)
            && !field_miss(alarm_ff[1], cur_time.min)
            && !field_miss(alarm_ff[2], cur_time.hour)
            && !field_miss(alarm_ff[3], cur_time.date)
            && !field_miss(alarm_ff[4], cur_time.month)
            && !field_miss(alarm_ff[5], cur_time.wday);
  end

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      nxt_alarm[i] = alarm_ff[i];
      if (wr_ok && reg_idx == 3'(i)) begin
        nxt_alarm[i] = reg_wdata;
      end
    end
    nxt_intc = intc_ff;
    if (wr_ok && reg_idx == REG_INTC_IDX) begin
      nxt_intc = reg_wdata;
    end
    nxt_flag = flag_ff;
    // Clear by writing zero to status; a same-cycle match wins
    if (wr_ok && reg_idx == REG_STAT_IDX && !reg_wdata[STAT_FLAG_BIT]) begin
      nxt_flag = 1'b0;
    end
    if (match) begin
      nxt_flag = 1'b1;
    end
    nxt_rdata = rdata_ff;
    if (reg_rd_en && bus_ff) begin
      if (reg_idx < REG_INTC_IDX) begin
        nxt_rdata = alarm_ff[reg_idx];
      end else if (reg_idx == REG_INTC_IDX) begin
        nxt_rdata = intc_ff;
      end else begin
        nxt_rdata = {7'h00, flag_ff};
      end
    end
    nxt_bus = bus_ok;
  end

  always_comb begin
    nxt_irq  = irq_ff;
    nxt_pcnt = pcnt_ff;
    case (irq_ff)
      RTA_IDLE: begin
        if (match && intc_ff[PULSE_SEL_BIT]) begin
          nxt_irq  = RTA_PULSE;
          nxt_pcnt = 8'(PULSE_CYC - 1);
        end else if (match) begin
          nxt_irq = RTA_HELD;
        end
      end
      RTA_HELD: begin
        // Single event holds until the flag is cleared
        if (!flag_ff) begin
          nxt_irq = RTA_IDLE;
        end
      end
      RTA_PULSE: begin
        // Pulse ends on its own; flag state is irrelevant
        if (pcnt_ff == 8'h00) begin
          nxt_irq = RTA_IDLE;
        end else begin
          nxt_pcnt = pcnt_ff - 8'h01;
        end
      end
      default: nxt_irq = RTA_IDLE;
    endcase
    nxt_irq_n = !(nxt_irq != RTA_IDLE);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 6; i++) begin
        alarm_ff[i] <= ALARM_RST;
      end
      intc_ff  <= INTC_RST;
      flag_ff  <= 1'b0;
      irq_ff   <= RTA_IDLE;
      pcnt_ff  <= 8'h00;
      rdata_ff <= 8'h00;
      bus_ff   <= 1'b0;
      lvr_ff   <= 1'b1;
      irq_n_ff <= 1'b1;
      oe_ff    <= 1'b1;
    end else begin
      for (int i = 0; i < 6; i++) begin
        alarm_ff[i] <= nxt_alarm[i];
      end
      intc_ff  <= nxt_intc;
      flag_ff  <= nxt_flag;
      irq_ff   <= nxt_irq;
      pcnt_ff  <= nxt_pcnt;
      rdata_ff <= nxt_rdata;
      bus_ff   <= nxt_bus;
      lvr_ff   <= !supply.vdd_above_reset;
      irq_n_ff <= nxt_irq_n;
      oe_ff    <= 1'b1;
    end
  end

  assign reg_rdata                 = rdata_ff;
  assign bus_enable                = bus_ff;
  assign alarm_interrupt_output_n  = irq_n_ff;
  // CMOS output: always driven, battery or not
  assign alarm_interrupt_output_oe = oe_ff;
  assign low_voltage_reset_state   = lvr_ff;

endmodule

// *** shared/rta_pkg.sv ***
// Purpose: constants and types for the alarm-zero match and backup bus gating block
// Assumes: registers are written over a simple write strobe from the serial bus engine
// Notes:   register indices are local choices; no offsets are printed for them
package rta_pkg;

  localparam logic [2:0] REG_SEC_IDX   = 3'h0;
  localparam logic [2:0] REG_MIN_IDX   = 3'h1;
  localparam logic [2:0] REG_HOUR_IDX  = 3'h2;
  localparam logic [2:0] REG_DATE_IDX  = 3'h3;
  localparam logic [2:0] REG_MONTH_IDX = 3'h4;
  localparam logic [2:0] REG_WDAY_IDX  = 3'h5;
  localparam logic [2:0] REG_INTC_IDX  = 3'h6;
  localparam logic [2:0] REG_STAT_IDX  = 3'h7;

  localparam int         MATCH_EN_BIT   = 7;
  localparam int         ALARM_EN_BIT   = 5;
  localparam int         PULSE_SEL_BIT  = 7;
  localparam int         STAT_FLAG_BIT  = 0;
  localparam logic [7:0] ALARM_RST      = 8'h00;
  localparam logic [7:0] INTC_RST       = 8'h00;
  localparam logic [6:0] BCD_MASK       = 7'h7F;

  // Pulse width in pulsed mode
  localparam int         PULSE_NS       = 250;
  localparam int         CLK_NS         = 50;
  localparam int         PULSE_CYC      = (PULSE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    RTA_MODE_A = 2'b00,
    RTA_MODE_B = 2'b01,
    RTA_MODE_C = 2'b10,
    RTA_MODE_D = 2'b11
  } rta_mode_e;

  typedef enum logic [1:0] {
    RTA_IDLE  = 2'b00,
    RTA_HELD  = 2'b01,
    RTA_PULSE = 2'b10
  } rta_irq_e;

  // Current calendar from the timekeeping counters, BCD
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] wday;
  } rta_time_s;

  // Supply comparator results
  typedef struct packed {
    logic vdd_above_reset;
    logic vbat_above_reset;
    logic vdd_above_vbat;
    logic on_battery;
  } rta_supply_s;

endpackage

// *** verif/rta_alarm_gate_tb_top.sv ***
// Purpose: directed register and alarm sequences for rta_alarm_gate
// Assumes: host model drives the register strobes
// Notes:   supply flags are forced as plain levels
`timescale 1ns/10ps
module rta_alarm_gate_tb_top import rta_pkg::*;;
  logic        ref_clk, rst_n, sec_tick, backup_switch_select, bus_in_backup_select;
  logic        reg_wr_en, reg_rd_en, bus_enable, alarm_interrupt_output_n;
  logic        alarm_interrupt_output_oe, low_voltage_reset_state;
  logic [2:0]  reg_idx;
  logic [7:0]  reg_wdata, reg_rdata, v;
  rta_time_s   cur_time;
  rta_supply_s supply;
  int          mismatches = 0, total_checks = 0, cyc = 0;
  rta_alarm_gate rta_alarm_gate_i (.*);
  rta_host_model host_i (.*);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick(input logic [7:0] s);
    @(negedge ref_clk);
    cur_time.sec = s;
    sec_tick = 1'b1;
    @(negedge ref_clk);
    sec_tick = 1'b0;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    sec_tick = 1'b0;
    cur_time = {8'h00, 8'h29, 8'h11, 8'h01, 8'h01, 8'h03};
    supply = 4'b1110;
    backup_switch_select = 1'b0;
    bus_in_backup_select = 1'b0;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    host_i.setup(56'h00_B0_91_81_81_00_20);
    host_i.rd(REG_MIN_IDX, v); chk(v, 8'hB0);
    tick(8'h59); chk(8'(alarm_interrupt_output_n), 8'h01);
    cur_time.min = 8'h30;
    tick(8'h00); chk(8'(alarm_interrupt_output_n), 8'h00);
    host_i.rd(REG_STAT_IDX, v); chk(8'(v[STAT_FLAG_BIT]), 8'h01);
    tick(8'h01);
    repeat (8) @(negedge ref_clk);
    chk(8'(alarm_interrupt_output_n), 8'h00);
    host_i.setup(56'hB0_00_00_00_00_00_A0);
    host_i.wr(REG_STAT_IDX, 8'h00);
    tick(8'h30); chk(8'(alarm_interrupt_output_n), 8'h00);
    repeat (PULSE_CYC - 1) @(negedge ref_clk);
    chk(8'(alarm_interrupt_output_n), 8'h00);
    @(negedge ref_clk);
    chk(8'(alarm_interrupt_output_n), 8'h01);
    tick(8'h31);
    host_i.wr(REG_STAT_IDX, 8'h00);
    host_i.rd(REG_STAT_IDX, v); chk(8'(v[STAT_FLAG_BIT]), 8'h00);
    tick(8'h30); chk(8'(alarm_interrupt_output_n), 8'h00);
    host_i.rd(REG_STAT_IDX, v); chk(8'(v[STAT_FLAG_BIT]), 8'h01);
    repeat (8) @(negedge ref_clk);
    host_i.wr(REG_INTC_IDX, 8'h80);
    tick(8'h30); chk(8'(alarm_interrupt_output_n), 8'h01);
    host_i.wr(REG_INTC_IDX, 8'hA0);
    supply = 4'b1111;
    tick(8'h30); chk(8'(alarm_interrupt_output_n), 8'h01);
    chk(8'(bus_enable), 8'h00);
    chk(8'(alarm_interrupt_output_oe), 8'h01);
    supply = 4'b0110;
    host_i.wr(REG_INTC_IDX, 8'h00);
    chk(8'(bus_enable), 8'h00);
    chk(8'(low_voltage_reset_state), 8'h01);
    supply = 4'b1110;
    host_i.rd(REG_INTC_IDX, v); chk(v, 8'hA0);
    backup_switch_select = 1'b1;
    supply = 4'b1101;
    repeat (2) @(negedge ref_clk);
    chk(8'(bus_enable), 8'h01);
    bus_in_backup_select = 1'b1;
    supply = 4'b1100;
    repeat (2) @(negedge ref_clk);
    chk(8'(bus_enable), 8'h00);
    end_of_test();
  end
endmodule

// *** verif/rta_gate_properties.sv ***
// Purpose: port checks for rta_alarm_gate
// Assumes: supply and mode inputs are synchronous levels
// Notes:   register contents are not visible here
`timescale 1ns/10ps
module rta_gate_properties
  import rta_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        sec_tick,
  input wire rta_supply_s supply,
  input wire logic        backup_switch_select,
  input wire logic        bus_in_backup_select,
  input wire logic        reg_rd_en,
  input wire logic [7:0]  reg_rdata,
  input wire logic        bus_enable,
  input wire logic        alarm_interrupt_output_n,
  input wire logic        alarm_interrupt_output_oe,
  input wire logic        low_voltage_reset_state
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic mode_d = backup_switch_select & bus_in_backup_select;
  lvr_follow_a: assert property (!supply.vdd_above_reset |=> low_voltage_reset_state) else $error("lvr low");
  bus_dead_a: assert property (!supply.vdd_above_reset |=> !bus_enable) else $error("bus on");
  std_backup_a: assert property (!backup_switch_select && supply.on_battery |=> !bus_enable) else $error("bus on");
  mode_b_a: assert property (backup_switch_select && !bus_in_backup_select && supply.on_battery
    && !supply.vbat_above_reset |=> !bus_enable) else $error("bus on");
  mode_d_off_a: assert property (mode_d && !supply.vdd_above_vbat |=> !bus_enable) else $error("bus on");
  mode_d_on_a: assert property (mode_d && supply.vdd_above_reset && supply.vdd_above_vbat |=> bus_enable)
    else $error("bus off");
  irq_driven_a: assert property (alarm_interrupt_output_oe) else $error("irq undriven");
  irq_cause_a: assert property ($fell(alarm_interrupt_output_n) |-> $past(sec_tick)) else $error("irq no tick");
  rdata_hold_a: assert property (!reg_rd_en |=> $stable(reg_rdata)) else $error("rdata moved");
endmodule
bind rta_alarm_gate rta_gate_properties rta_gate_properties_i (.*);

// *** verif/rta_host_model.sv ***
// Purpose: host side of the register access path
// Assumes: strobes change at the falling edge
// Notes:   released data is inverted to hide stale values
`timescale 1ns/10ps
module rta_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic [2:0]      reg_idx,
  output logic [7:0]      reg_wdata
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_idx   = 3'h0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    @(negedge ref_clk);
    reg_idx   = i;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [2:0] i, output logic [7:0] d);
    @(negedge ref_clk);
    reg_idx   = i;
    reg_rd_en = 1'b1;
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
    d = reg_rdata;
  endtask
  task automatic setup(input logic [55:0] v);
    for (int i = 0; i < 7; i++) begin
      wr(3'(i), v[55-8*i -: 8]);
    end
  endtask
endmodule
